// ==== ifpf_pkg.sv ====
/*
 * Shared constants, types and helpers for the pixel-path stage: register
 * map, field positions, reset values, modes and the pixel carriers.
 * Assumes a single pixel clock and a small fixed frame buffer geometry.
 */
`default_nettype none

package ifpf_pkg;

	// ==========================================================
	// Geometry
	localparam int IMG_W  = 16;
	localparam int IMG_H  = 8;
	localparam int ADDR_W = 8;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_PATSEL = 8'h04;
	localparam logic [7:0] REG_PATCH  = 8'h08;
	localparam logic [7:0] REG_ROI    = 8'h0c;
	localparam logic [7:0] REG_BLACK  = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;

	// ==========================================================
	// Field positions
	localparam int CTRL_ACQ_BIT   = 0;
	localparam int CTRL_REVX_BIT  = 1;
	localparam int CTRL_REVY_BIT  = 2;
	localparam int CTRL_FMT_LSB   = 4;
	localparam int CTRL_DEPTH_LSB = 8;
	localparam int CTRL_PHASE_LSB = 12;
	localparam int ROI_X_LSB      = 0;
	localparam int ROI_W_LSB      = 8;
	localparam int ROI_Y_LSB      = 16;
	localparam int ROI_H_LSB      = 24;
	localparam int ST_FRAME_LSB   = 0;
	localparam int ST_STATE_LSB   = 8;
	localparam int ST_PHASE_LSB   = 12;

	// ==========================================================
	// Reset values
	localparam logic [31:0] CTRL_RST  = 32'h0000_0100;
	localparam logic [31:0] ROI_RST   = 32'h0800_1000;
	localparam logic [13:0] BLACK_RST = 14'h0000;

	// ==========================================================
	// Modes
	typedef enum logic [1:0] {
		FMT_MONO8                         = 2'b00,
		FMT_MONO16                        = 2'b01,
		FMT_LUMA_CHROMA_QUARTER_RATE_8BIT = 2'b10
	} ifpf_fmt_t;

	typedef enum logic [1:0] {
		DEPTH_10 = 2'b00,
		DEPTH_12 = 2'b01,
		DEPTH_14 = 2'b10
	} ifpf_depth_t;

	typedef enum logic [1:0] {
		PAT_OFF      = 2'b00,
		PAT_SENSOR   = 2'b01,
		PAT_INCR     = 2'b10,
		PAT_VARFRAME = 2'b11
	} ifpf_pat_t;

	typedef enum logic [1:0] {
		PH_MOSAIC_RED_GREEN  = 2'b00,
		PH_MOSAIC_GREEN_RED  = 2'b01,
		PH_MOSAIC_GREEN_BLUE = 2'b10,
		PH_MOSAIC_BLUE_GREEN = 2'b11
	} ifpf_phase_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_FILL  = 2'b01,
		ST_DRAIN = 2'b10
	} ifpf_state_t;

	// ==========================================================
	// Pixel carriers
	typedef struct packed {
		logic        valid;
		logic        frameStart;
		logic [13:0] raw;
		logic [7:0]  red;
		logic [7:0]  green;
		logic [7:0]  blue;
	} ifpf_sensor_t;

	typedef struct packed {
		logic        valid;
		logic        frameStart;
		logic        lineEnd;
		logic [15:0] word;
		logic        cbcrValid;
		logic [7:0]  cb;
		logic [7:0]  cr;
	} ifpf_pix_t;

	// ==========================================================
	// Helpers
	function automatic logic [15:0] fitSample(input logic [13:0] raw,
	                                          input ifpf_depth_t depth);
		case (depth)
			DEPTH_10: fitSample = {raw[9:0], 6'h00};
			DEPTH_14: fitSample = {raw[13:0], 2'h0};
			default:  fitSample = {raw[11:0], 4'h0};
		endcase
	endfunction : fitSample

	// Coefficients sum to 256 so full-scale input gives full-scale output
	function automatic logic [7:0] lumaOf(input logic [23:0] rgb);
		logic [17:0] acc;
		acc = 18'(rgb[23:16]) * 18'd77 + 18'(rgb[15:8]) * 18'd150
		    + 18'(rgb[7:0]) * 18'd29;
		lumaOf = acc[15:8];
	endfunction : lumaOf

	// Bias of 128 in the top byte keeps the sum non-negative
	function automatic logic [7:0] diffOf(input logic [7:0] pos,
	                                      input logic [7:0] negA,
	                                      input logic [7:0] coA,
	                                      input logic [7:0] negB,
	                                      input logic [7:0] coB);
		logic [17:0] acc;
		acc = 18'h08000 + 18'({pos, 7'h00}) - 18'(negA) * 18'(coA)
		    - 18'(negB) * 18'(coB);
		diffOf = acc[15:8];
	endfunction : diffOf

endpackage : ifpf_pkg

`default_nettype wire

// ==== ifpf_top.sv ====
/*
 * Pixel-path stage: bit-depth fitting, 4:1:1 luma-chroma output, two test
 * pattern generators, horizontal/vertical flip ahead of ROI crop.
 * Assumes a sensor stream synchronous to sys_clk, whole frames of
 * IMG_W x IMG_H pixels, and a host on the plain register port.
 */
`default_nettype none

// Contract
// R1: 4:1:1 output keeps every luma, one Cb and Cr per four pixels.
// R2: Luma and chroma span full 8-bit range for full-range RGB.
// R3: Narrower pixel format drops the lowest ADC bits.
// R4: Wider pixel format pads the low bits with ignorable zeros.
// R5: Samples sit left-justified, MSB first, in a 16-bit word.
// R6: Twelve-bit samples pad the four low bits, mask 0xFFF0.
// R7: Full scale is 65472, 65520, 65532 for 10, 12, 14 bits.
// R8: Host stops acquisition before changing ADC depth.
// R9: Source select picks which generator the pattern setting drives.
// R10: Off disables only the selected generator.
// R11: Sensor generator accepts only the sensor-specific pattern.
// R12: Increment pattern adds one per pixel, wrapping after 255.
// R13: Variable frame pattern changes per frame, restarts on acquisition.
// R14: Pipeline pattern overrides sensor pattern when both enabled.
// R15: Downstream formatting still acts on pattern pixels.
// R16: Black level does not touch pattern pixels.
// R17: Host turns off auto exposure and auto gain during patterns.
// R18: Real sensor data only when both generators are off.
// R19: Horizontal flip reverses pixels in a line, crop after flip.
// R20: Vertical flip reverses line order, crop after flip.
// R21: Reported mosaic phase follows the flips.
// R22: Single clock, synchronous reset clears generators and flips.

module ifpf_top
	import ifpf_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               rst,
	input  wire logic               ce,
	input  wire logic [ADDR_W-1:0]  regAddr,
	input  wire logic [31:0]        wrData,
	input  wire logic               wrStrobe,
	input  wire logic               rdStrobe,
	output logic      [31:0]        rdData,
	input  wire ifpf_sensor_t       sensorIn,
	output ifpf_pix_t               pixOut,
	output ifpf_phase_t             mosaicPhase
);

	// ==========================================================
	// Control registers
	logic        acquire;
	logic        revX;
	logic        revY;
	ifpf_fmt_t   pixFormat;
	ifpf_depth_t adcDepth;
	ifpf_phase_t basePhase;
	logic        patternSourceSelect;
	ifpf_pat_t   sensorPattern;
	ifpf_pat_t   pipePattern;
	logic [3:0]  roiX;
	logic [4:0]  roiW;
	logic [2:0]  roiY;
	logic [3:0]  roiH;
	logic [13:0] blackLevel;

	logic [31:0] ctrlView;
	logic [31:0] roiView;
	ifpf_pat_t   choiceView;
	ifpf_pat_t   wrChoice;

	assign wrChoice = ifpf_pat_t'(wrData[1:0]);
	assign choiceView = patternSourceSelect ? pipePattern : sensorPattern;
	assign ctrlView = {16'h0000, 2'b00, basePhase, 2'b00, adcDepth,
	                   2'b00, pixFormat, 1'b0, revY, revX, acquire};
	assign roiView = {4'h0, roiH, 5'h00, roiY, 3'h0, roiW, 4'h0, roiX};

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			acquire   <= CTRL_RST[CTRL_ACQ_BIT];
			revX      <= CTRL_RST[CTRL_REVX_BIT]; // R22
			revY      <= CTRL_RST[CTRL_REVY_BIT]; // R22
			pixFormat <= ifpf_fmt_t'(CTRL_RST[CTRL_FMT_LSB +: 2]);
			adcDepth  <= ifpf_depth_t'(CTRL_RST[CTRL_DEPTH_LSB +: 2]);
			basePhase <= ifpf_phase_t'(CTRL_RST[CTRL_PHASE_LSB +: 2]);
		end else if (ce && wrStrobe && regAddr == REG_CTRL) begin
			acquire   <= wrData[CTRL_ACQ_BIT];
			revX      <= wrData[CTRL_REVX_BIT];
			revY      <= wrData[CTRL_REVY_BIT];
			pixFormat <= ifpf_fmt_t'(wrData[CTRL_FMT_LSB +: 2]);
			basePhase <= ifpf_phase_t'(wrData[CTRL_PHASE_LSB +: 2]);
			// Depth only moves while stopped; a live change would mix
			// two scalings inside one frame
			if (!acquire && !wrData[CTRL_ACQ_BIT]) begin
				adcDepth <= ifpf_depth_t'(wrData[CTRL_DEPTH_LSB +: 2]); // R8
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			patternSourceSelect <= 1'b0;
			sensorPattern       <= PAT_OFF; // R22
			pipePattern         <= PAT_OFF; // R22
		end else if (ce && wrStrobe && regAddr == REG_PATSEL) begin
			patternSourceSelect <= wrData[0]; // R9
		end else if (ce && wrStrobe && regAddr == REG_PATCH) begin
			if (patternSourceSelect) begin // R9
				if (wrChoice != PAT_SENSOR) begin
					pipePattern <= wrChoice; // R10
				end
			end else if (wrChoice == PAT_OFF || wrChoice == PAT_SENSOR) begin
				sensorPattern <= wrChoice; // R11
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			roiX       <= ROI_RST[ROI_X_LSB +: 4];
			roiW       <= ROI_RST[ROI_W_LSB +: 5];
			roiY       <= ROI_RST[ROI_Y_LSB +: 3];
			roiH       <= ROI_RST[ROI_H_LSB +: 4];
			blackLevel <= BLACK_RST;
		end else if (ce && wrStrobe && regAddr == REG_ROI) begin
			roiX <= wrData[ROI_X_LSB +: 4];
			roiW <= wrData[ROI_W_LSB +: 5];
			roiY <= wrData[ROI_Y_LSB +: 3];
			roiH <= wrData[ROI_H_LSB +: 4];
		end else if (ce && wrStrobe && regAddr == REG_BLACK) begin
			blackLevel <= wrData[13:0];
		end
	end

	// ==========================================================
	// Frame capture with pattern injection
	ifpf_state_t state;
	logic [3:0]  inCol;
	logic [2:0]  inRow;
	logic [7:0]  incrCount;
	logic [7:0]  frameNum;
	logic        acquireDly;
	logic [23:0] frameMem [0:IMG_W*IMG_H-1];

	logic        takePix;
	logic        lastIn;
	logic [13:0] sensorRaw;
	logic [13:0] rawLevel;
	logic [7:0]  pipeGrey;
	logic [23:0] entry;
	logic [15:0] fitted;

	assign takePix = sensorIn.valid && (state == ST_FILL ||
	                 (state == ST_IDLE && acquire && sensorIn.frameStart));
	assign lastIn = inCol == 4'(IMG_W - 1) && inRow == 3'(IMG_H - 1);

	always_comb begin
		// Black level is an analog-side control and never shifts
		// synthetic pixels
		rawLevel = sensorIn.raw > blackLevel ?
		           sensorIn.raw - blackLevel : 14'h0000;
		if (sensorPattern == PAT_SENSOR) begin
			sensorRaw = {inCol, inRow, inCol, inRow}; // R16
		end else begin
			sensorRaw = rawLevel; // R18
		end
		if (pipePattern == PAT_INCR) begin
			pipeGrey = incrCount; // R12
		end else begin
			pipeGrey = 8'({inCol, 3'h0}) + 8'({inRow, 2'h0})
			         + 8'({frameNum[3:0], 4'h0}); // R13
		end
		fitted = fitSample(sensorRaw, adcDepth); // R5
		if (pipePattern != PAT_OFF) begin
			// Pipeline pattern wins over anything from the sensor side
			case (pixFormat) // R14
				FMT_MONO16: entry = {8'h00, pipeGrey, 8'h00};
				FMT_MONO8:  entry = {16'h0000, pipeGrey};
				default:    entry = {pipeGrey, pipeGrey, pipeGrey};
			endcase
		end else begin
			case (pixFormat)
				FMT_MONO16: entry = {8'h00, fitted}; // R4
				FMT_MONO8:  entry = {16'h0000, fitted[15:8]}; // R3
				default: begin
					if (sensorPattern == PAT_SENSOR) begin
						entry = {3{fitted[15:8]}};
					end else begin
						entry = {sensorIn.red, sensorIn.green,
						         sensorIn.blue}; // R18
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (ce && takePix) begin
			frameMem[{inRow, inCol}] <= entry;
		end
	end

	// Sequences restart on the rising edge of acquisition
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			acquireDly <= 1'b0;
			incrCount  <= 8'h00;
			frameNum   <= 8'h00;
		end else if (ce) begin
			acquireDly <= acquire;
			if (acquire && !acquireDly) begin
				incrCount <= 8'h00; // R12
				frameNum  <= 8'h00; // R13
			end else if (takePix) begin
				incrCount <= incrCount + 8'h01; // R12
				if (lastIn) begin
					frameNum <= frameNum + 8'h01; // R13
				end
			end
		end
	end

	// ==========================================================
	// Sequencer and flipped, cropped readout
	logic [3:0]  outCol;
	logic [3:0]  outRow;
	logic        lastOutCol;
	logic        lastOutRow;
	logic [3:0]  srcCol;
	logic [2:0]  srcRow;
	logic [23:0] rdEntry;

	assign lastOutCol = outCol == 4'(roiW - 5'd1);
	assign lastOutRow = outRow == roiH - 4'h1;

	always_comb begin
		srcCol = roiX + outCol;
		srcRow = roiY + outRow[2:0];
		if (revX) begin
			srcCol = 4'(IMG_W - 1) - srcCol; // R19
		end
		if (revY) begin
			srcRow = 3'(IMG_H - 1) - srcRow; // R20
		end
		rdEntry = frameMem[{srcRow, srcCol}];
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state  <= ST_IDLE;
			inCol  <= 4'h0;
			inRow  <= 3'h0;
			outCol <= 4'h0;
			outRow <= 4'h0;
		end else if (ce) begin
			case (state)
				ST_IDLE: begin
					if (takePix) begin
						inCol <= 4'h1;
						inRow <= 3'h0;
						state <= ST_FILL;
					end
				end
				ST_FILL: begin
					if (takePix) begin
						inCol <= inCol + 4'h1;
						if (inCol == 4'(IMG_W - 1)) begin
							inRow <= inRow + 3'h1;
						end
						if (lastIn) begin
							outCol <= 4'h0;
							outRow <= 4'h0;
							state  <= ST_DRAIN;
						end
					end
				end
				ST_DRAIN: begin
					outCol <= lastOutCol ? 4'h0 : outCol + 4'h1;
					if (lastOutCol) begin
						outRow <= outRow + 4'h1;
						if (lastOutRow) begin
							inCol <= 4'h0;
							inRow <= 3'h0;
							state <= ST_IDLE;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Output formatting, applied to real and pattern pixels alike
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pixOut <= '0;
		end else if (ce) begin
			pixOut.valid      <= state == ST_DRAIN;
			pixOut.frameStart <= state == ST_DRAIN && outCol == 4'h0 &&
			                     outRow == 4'h0;
			pixOut.lineEnd    <= state == ST_DRAIN && lastOutCol;
			pixOut.cbcrValid  <= 1'b0;
			if (pixFormat == FMT_LUMA_CHROMA_QUARTER_RATE_8BIT) begin
				pixOut.word <= {8'h00, lumaOf(rdEntry)}; // R1 R2 R15
				// Chroma of the first pixel stands for its group of four
				pixOut.cbcrValid <= state == ST_DRAIN &&
				                    outCol[1:0] == 2'b00; // R1
				pixOut.cb <= diffOf(rdEntry[7:0], rdEntry[23:16], 8'd43,
				                    rdEntry[15:8], 8'd85); // R2
				pixOut.cr <= diffOf(rdEntry[23:16], rdEntry[15:8], 8'd107,
				                    rdEntry[7:0], 8'd21); // R2
			end else begin
				pixOut.word <= rdEntry[15:0]; // R5 R6 R7 R15
			end
		end
	end

	// Phase code bits line up with the two flips
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mosaicPhase <= PH_MOSAIC_RED_GREEN;
		end else if (ce) begin
			mosaicPhase <= ifpf_phase_t'(basePhase ^ {revY, revX}); // R21
		end
	end

	// ==========================================================
	// Register read port
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdData <= 32'h0000_0000;
		end else if (ce) begin
			rdData <= 32'h0000_0000;
			if (rdStrobe) begin
				case (regAddr)
					REG_CTRL:   rdData <= ctrlView;
					REG_PATSEL: rdData <= {31'h0, patternSourceSelect};
					REG_PATCH:  rdData <= {30'h0, choiceView};
					REG_ROI:    rdData <= roiView;
					REG_BLACK:  rdData <= {18'h0, blackLevel};
					REG_STATUS: rdData <= {16'h0, 2'b00, mosaicPhase,
					                       2'b00, state, frameNum};
					default:    rdData <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule : ifpf_top

`default_nettype wire

// ==== ifpf_top_properties.sv ====
/*
 * Port checker for the pixel-path stage, bound to its top module.
 * Assumes ce high during CTRL and ROI writes, and writes only between frames.
 */
`default_nettype none

module ifpf_top_properties
	import ifpf_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              rst,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [31:0]       wrData,
	input wire logic              wrStrobe,
	input wire logic              rdStrobe,
	input wire logic [31:0]       rdData,
	input wire ifpf_pix_t         pixOut,
	input wire ifpf_phase_t       mosaicPhase
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Shadow of format and depth; depth moves only with acquire off
	logic        acq;
	logic [1:0]  fmt;
	logic [1:0]  dep;
	logic [15:0] pad;
	logic        roiBig;
	logic        roiQuad;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			acq <= 1'b0;
			fmt <= 2'b00;
			dep <= 2'b01;
			roiBig <= 1'b1;
			roiQuad <= 1'b1;
		end else if (wrStrobe && regAddr == REG_ROI) begin
			// Small crops and widths off a multiple of four are legal; the burst
			// check only holds for the larger ones, chroma spacing for multiples of four
			roiBig <= int'(wrData[12:8]) * int'(wrData[27:24]) >= 8;
			roiQuad <= wrData[9:8] == 2'b00;
		end else if (wrStrobe && regAddr == REG_CTRL) begin
			acq <= wrData[0];
			fmt <= wrData[5:4];
			if (!acq && !wrData[0])
				dep <= wrData[9:8];
		end
	end
	assign pad = dep == 2'b00 ? 16'h003f :
	             dep == 2'b10 ? 16'h0003 : 16'h000f;
	// ==========================================================
	// Properties
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_burst;
		pixOut.valid [*8];
	endsequence
	sequence s_chroma_gap;
		!pixOut.cbcrValid [*3];
	endsequence
	a_rd_idle_zero: assert property (!$past(rdStrobe) |-> rdData == 32'h0)
		else $error("read data outside its slot");
	a_unmapped_zero: assert property (rdStrobe && regAddr == 8'h18
		|=> rdData == 32'h0) else $error("unmapped read not zero");
	a_phase_follow: assert property (rdStrobe && regAddr == REG_CTRL
		|=> mosaicPhase == (rdData[13:12] ^ {rdData[2], rdData[1]}))
		else $error("mosaic phase does not follow flips");
	a_marks_valid: assert property (pixOut.frameStart || pixOut.lineEnd
		|| pixOut.cbcrValid |-> pixOut.valid)
		else $error("marker without pixel");
	a_burst_start: assert property ($rose(pixOut.valid)
		&& roiBig |-> pixOut.frameStart ##0 s_burst)
		else $error("broken drain");
	a_frame_gap: assert property (pixOut.frameStart
		|-> !$past(pixOut.valid)) else $error("frames not separated");
	a_byte_high: assert property (pixOut.valid && fmt != 2'b01
		|-> pixOut.word[15:8] == 8'h00) else $error("upper byte set");
	a_pad_low: assert property (pixOut.valid && fmt == 2'b01
		|-> (pixOut.word & pad) == 16'h0000) else $error("padding set");
	a_chroma_gap: assert property (pixOut.cbcrValid && fmt == 2'b10
		&& roiQuad |=> s_chroma_gap) else $error("chroma closer than four");
	a_chroma_first: assert property (pixOut.frameStart && fmt == 2'b10
		|-> pixOut.cbcrValid) else $error("no chroma at origin");
endmodule : ifpf_top_properties

`default_nettype wire

// ==== ifpf_sensor_src.sv ====
/*
 * Sensor source model: one 16x8 frame per go pulse, raw = {idx, idx}.
 * Assumes go only while the stage is idle; idle lines carry noise.
 */
`default_nettype none

module ifpf_sensor_src
	import ifpf_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        go,
	output var ifpf_sensor_t sensorIn
);
	timeunit 1ns;
	timeprecision 1ps;
	int         seed = 93;
	logic [7:0] idx  = 8'h80;
	logic [7:0] nxt;
	initial sensorIn = '0;
	// Rows pick pure colours so full-scale chroma is reached
	always @(posedge sys_clk) begin
		nxt = go ? 8'h00 : idx + {7'h00, !idx[7]};
		idx <= nxt;
		sensorIn.valid <= !nxt[7];
		sensorIn.frameStart <= nxt == 8'h00;
		if (nxt[7]) begin
			sensorIn.raw <= 14'($random(seed));
			sensorIn.red <= 8'($random(seed));
			sensorIn.green <= 8'($random(seed));
			sensorIn.blue <= 8'($random(seed));
		end else begin
			sensorIn.raw <= {nxt[6:0], nxt[6:0]};
			sensorIn.red <= {8{nxt[4]}};
			sensorIn.green <= {8{nxt[5]}};
			sensorIn.blue <= {8{nxt[6]}};
		end
	end
endmodule : ifpf_sensor_src

`default_nettype wire

// ==== image_format_pattern_flip_bench.sv ====
/*
 * Bench: register host, frame source, queued expectations, watchers.
 * Assumes one frame in flight at a time; ce drops once, before the first frame.
 */
`default_nettype none

bind ifpf_top ifpf_top_properties u_props (.sys_clk(sys_clk), .rst(rst),
	.regAddr(regAddr), .wrData(wrData), .wrStrobe(wrStrobe),
	.rdStrobe(rdStrobe), .rdData(rdData), .pixOut(pixOut),
	.mosaicPhase(mosaicPhase));

module image_format_pattern_flip_bench
	import ifpf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic         sys_clk = 1'b0;
	logic         rst = 1'b1;
	logic         ce = 1'b1;
	logic [7:0]   regAddr = 8'h00;
	logic [31:0]  wrData = 32'h0;
	logic         wrStrobe = 1'b0;
	logic         rdStrobe = 1'b0;
	logic         go = 1'b0;
	logic [31:0]  rdData;
	ifpf_sensor_t sensorIn;
	ifpf_pix_t    pixOut;
	ifpf_phase_t  mosaicPhase;
	logic [31:0]  ctl, roi;
	logic         chromaOn, rdSeen = 1'b0;
	int           gbase, n_fail = 0, n_compared = 0;
	ifpf_pix_t    pixQ[$];
	ifpf_pix_t    p, e;
	logic [31:0]  regQ[$];
	localparam logic [31:0] CFG [6] = '{32'h0011, 32'h0111, 32'h0211,
		32'h0103, 32'h0215, 32'h1127};
	always #5 sys_clk = ~sys_clk;
	ifpf_top u_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce),
		.regAddr(regAddr), .wrData(wrData), .wrStrobe(wrStrobe),
		.rdStrobe(rdStrobe), .rdData(rdData), .sensorIn(sensorIn),
		.pixOut(pixOut), .mosaicPhase(mosaicPhase));
	ifpf_sensor_src u_src (.sys_clk(sys_clk), .go(go), .sensorIn(sensorIn));
	// ==========================================================
	// Tasks
	task automatic bad(string m);
		n_fail++;
		$display("wrong value at %0t ns: %s", $time, m);
	endtask : bad
	task automatic report_and_stop();
		if (n_fail == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge sys_clk);
		wrStrobe <= 1'b1;
		regAddr <= a;
		wrData <= d;
		@(posedge sys_clk);
		wrStrobe <= 1'b0;
	endtask : wr
	task automatic rd(logic [7:0] a, logic [31:0] x);
		@(posedge sys_clk);
		rdStrobe <= 1'b1;
		regAddr <= a;
		regQ.push_back(x);
		@(posedge sys_clk);
		rdStrobe <= 1'b0;
	endtask : rd
	// Depth only lands while acquisition is off, hence three writes
	task automatic setup(logic [31:0] c, logic [31:0] r);
		ctl = c;
		roi = r;
		gbase = 0;
		chromaOn = c[5:4] == 2'b10;
		wr(REG_CTRL, 32'h0);
		wr(REG_CTRL, c & ~32'h1);
		wr(REG_CTRL, c);
		wr(REG_ROI, r);
	endtask : setup
	// src: 0 sensor data, 1 sensor pattern, 2 increment, 3 frame sequence
	task automatic frame(int src);
		int fr, fc, idx, rv, gv, bv;
		logic [13:0] raw;
		logic [15:0] fit;
		ifpf_pix_t n;
		ifpf_phase_t phaseExp;
		for (int r = 0; r < roi[27:24]; r++) begin
			for (int c = 0; c < roi[12:8]; c++) begin
				fr = ctl[2] ? 7 - (roi[18:16] + r) : roi[18:16] + r;
				fc = ctl[1] ? 15 - (roi[3:0] + c) : roi[3:0] + c;
				idx = fr * 16 + fc;
				raw = src == 1 ? {4'(fc), 3'(fr), 4'(fc), 3'(fr)}
				               : {7'(idx), 7'(idx)};
				fit = 16'({2'b00, raw} << (6 - 2 * ctl[9:8]));
				rv = idx[4] ? 255 : 0;
				gv = idx[5] ? 255 : 0;
				bv = idx[6] ? 255 : 0;
				n = '0;
				n.valid = 1'b1;
				n.frameStart = r == 0 && c == 0;
				n.lineEnd = c == roi[12:8] - 1;
				n.cbcrValid = c % 4 == 0;
				n.cb = 8'((128 * bv - 43 * rv - 85 * gv + 32768) >> 8);
				n.cr = 8'((128 * rv - 107 * gv - 21 * bv + 32768) >> 8);
				case (ctl[5:4])
					2'b01: n.word = fit;
					2'b10: n.word = 16'((77 * rv + 150 * gv + 29 * bv) >> 8);
					default: n.word = {8'h00,
						src == 2 ? 8'(gbase + idx) :
						src == 3 ? 8'(8 * fc + 4 * fr + gbase / 8) :
						fit[15:8]};
				endcase
				pixQ.push_back(n);
			end
		end
		@(posedge sys_clk) go <= 1'b1;
		@(posedge sys_clk) go <= 1'b0;
		for (int k = 0; k < 400 && pixQ.size() > 0; k++)
			@(posedge sys_clk);
		if (pixQ.size() != 0) begin
			bad("pixels missing");
			pixQ.delete();
		end
		gbase += 128;
		repeat (4) @(posedge sys_clk);
		n_compared++;
		phaseExp = ifpf_phase_t'(ctl[13:12] ^ {ctl[2], ctl[1]});
		if (mosaicPhase !== phaseExp) bad("mosaic phase");
	endtask : frame
	// ==========================================================
	// Watchers: oldest note against each result
	always @(posedge sys_clk) begin
		if (rdSeen) begin
			n_compared++;
			if (rdData !== regQ.pop_front()) bad("register read");
		end
		rdSeen = rdStrobe;
		p = pixOut;
		if (p.valid === 1'b1) begin
			n_compared++;
			if (pixQ.size() == 0) bad("extra pixel");
			else begin
				e = pixQ.pop_front();
				if ({p.frameStart, p.lineEnd, p.word} !==
				    {e.frameStart, e.lineEnd, e.word}) bad("pixel word");
				if (chromaOn && (p.cbcrValid !== e.cbcrValid ||
				    (e.cbcrValid && {p.cb, p.cr} !== {e.cb, e.cr})))
					bad("chroma");
			end
		end
	end
	initial begin
		repeat (10000) @(posedge sys_clk);
		bad("timeout");
		report_and_stop();
	end
	// ==========================================================
	// Main sequence
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		for (int k = 0; k < 7; k++)
			rd(8'(4 * k), k == 0 ? CTRL_RST : k == 3 ? ROI_RST : 32'h0);
		// A write while the enable is low must leave no trace
		@(posedge sys_clk) ce <= 1'b0;
		wr(REG_BLACK, 32'h0123);
		ce <= 1'b1;
		rd(REG_BLACK, 32'h0);
		for (int k = 0; k < 6; k++) begin
			setup(CFG[k], k == 4 ? 32'h0202_0404 : ROI_RST);
			frame(0);
		end
		wr(REG_CTRL, 32'h1027);
		rd(REG_CTRL, 32'h1127);
		setup(32'h0211, ROI_RST);
		wr(REG_BLACK, 32'h0100);
		wr(REG_PATCH, 32'h1);
		frame(1);
		wr(REG_PATCH, 32'h2);
		rd(REG_PATCH, 32'h1);
		setup(32'h0101, ROI_RST);
		wr(REG_PATSEL, 32'h1);
		wr(REG_PATCH, 32'h2);
		repeat (3) frame(2);
		wr(REG_PATCH, 32'h3);
		frame(3);
		setup(32'h0101, ROI_RST);
		frame(3);
		wr(REG_PATCH, 32'h0);
		wr(REG_PATSEL, 32'h0);
		rd(REG_PATCH, 32'h1);
		frame(1);
		wr(REG_PATCH, 32'h0);
		wr(REG_BLACK, 32'h0);
		frame(0);
		report_and_stop();
	end
endmodule : image_format_pattern_flip_bench

`default_nettype wire
